//--- design/tsdr_consts.svh
// offsets, field positions and timing counts of the tile status/debug bank
// assumes: included by bare name from the package and the top module
`ifndef TSDR_CONSTS_SVH
`define TSDR_CONSTS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define TSDR_OFS_OSC_CTRL 8'h06
`define TSDR_OFS_OSC_CNT0 8'h07
`define TSDR_OFS_OSC_CNT1 8'h08
`define TSDR_OFS_OSC_CNT2 8'h09
`define TSDR_OFS_OSC_CNT3 8'h0A
`define TSDR_OFS_RAM_SIZE 8'h0C
`define TSDR_OFS_DBG_SSW 8'h10
`define TSDR_OFS_DBG_SPC 8'h11
`define TSDR_OFS_DBG_SSP 8'h12
`define TSDR_OFS_FETCH_THR 8'h13
`define TSDR_OFS_FETCH_REG 8'h14

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define TSDR_BIT_CORE_OSC_EN 1
`define TSDR_BIT_PERIPH_OSC_EN 0
`define TSDR_OSC_CTRL_RST 2'h0
`define TSDR_OSC_CNT_W 16
`define TSDR_SSW_W 11
`define TSDR_SSW_BIT_ISSUE 8
`define TSDR_SSW_BIT_RSVD 5
`define TSDR_SSW_WMASK 11'h6DF
`define TSDR_THR_W 8
`define TSDR_REG_W 5
`define TSDR_RAM_BYTES_DEF 32'h0008_0000

// ----------------------------------------
// timing
// ----------------------------------------
`define TSDR_STOP_SETTLE_CYC 10
`define TSDR_SYNC_STAGES 2

`endif

//--- design/tsdr_pkg.sv
// types shared by the tile status/debug bank
// assumes: constants come from tsdr_consts.svh
`include "tsdr_consts.svh"

package tsdr_pkg;

  // status register access request, one cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [31:0] wdata;
  } tsdr_req_t;

  // debugger entry capture bundle
  typedef struct packed {
    logic [`TSDR_SSW_W-1:0] ssw;
    logic [31:0] saved_program_counter;
    logic [31:0] saved_stack_pointer;
  } tsdr_capt_t;

  // run state of all four oscillators taken together, seen by the core clock
  typedef enum logic [1:0] {
    TSDR_OSC_STOPPED,
    TSDR_OSC_RUNNING,
    TSDR_OSC_SETTLING
  } tsdr_osc_st_t;

endpackage

//--- design/tsdr_tile_status_debug_regs.sv
// tile status/debug register bank: ring oscillator control and counts,
// ram size, and the debug capture and register-fetch operand registers.
// assumes: the core issues one status access per cycle on req; the four
// oscillator clocks arrive as free-running inputs gated here by the enables.
//
// Overview of operation
// RULE1: four free-running ring oscillators, own counters
// RULE2: control bit1 core, bit0 periph enable
// RULE3: software reads counts after 10-cycle stop
// RULE4: counts usable as random bit source
// RULE5: counts readable at indices 0x07..0x0A
// RULE6: count in 15:0, upper bits zero
// RULE7: counts survive system reset
// RULE8: ram size bytes in bits 31:2
// RULE9: debugger entry captures saved status word
// RULE10: bits 4..0 kernel, irq, event-seq, ie, ee
// RULE11: bit7 fast, bit6 paused, bit5 reserved
// RULE12: bit10 asid, bit9 entry issue, bit8 ro
// RULE13: debugger entry captures saved program counter
// RULE14: debugger entry captures saved stack pointer
// RULE15: fetch operand one thread number 7:0
// RULE16: fetch operand two register number 4:0
// RULE17: debug-writable fields writable only in debug
`timescale 1ns/100ps
`include "tsdr_consts.svh"

module tsdr_tile_status_debug_regs #(
  parameter logic [31:0] RAM_BYTES = `TSDR_RAM_BYTES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire tsdr_pkg::tsdr_req_t req,
  output logic [31:0] rdata,
  output logic rvalid,
  input wire logic debug_mode,
  input wire logic debug_entry,
  input wire tsdr_pkg::tsdr_capt_t capt,
  input wire logic cur_issue_mode,
  input wire logic [3:0] osc_clk,
  output logic core_osc_en,
  output logic periph_osc_en,
  output logic [`TSDR_THR_W-1:0] debug_register_fetch_thread,
  output logic [`TSDR_REG_W-1:0] debug_register_fetch_reg,
  output logic counts_settled
);

  // ----------------------------------------
  // oscillator control
  // ----------------------------------------
  logic [1:0] osc_ctrl_q;
  logic ctrl_wr;
  assign ctrl_wr = req.wr && (req.idx == `TSDR_OFS_OSC_CTRL);

  // software starts and stops the oscillators here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_ctrl_q <= `TSDR_OSC_CTRL_RST;
    end else if (clk_en && ctrl_wr) begin
      osc_ctrl_q <= req.wdata[1:0]; // [RULE2]
    end
  end

  assign core_osc_en = osc_ctrl_q[`TSDR_BIT_CORE_OSC_EN];
  assign periph_osc_en = osc_ctrl_q[`TSDR_BIT_PERIPH_OSC_EN];

  // ----------------------------------------
  // oscillator counters
  // ----------------------------------------
  // counters 0,1 belong to the tile core, 2,3 to the periphery
  logic [3:0] osc_gate;
  assign osc_gate = {periph_osc_en, periph_osc_en, core_osc_en, core_osc_en};

  // count values as the read path sees them
  logic [`TSDR_OSC_CNT_W-1:0] osc_cnt [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_osc
      logic en_s1_q;
      logic en_s2_q;
      // power-up value only: no reset input, so a system reset leaves it alone
      logic [`TSDR_OSC_CNT_W-1:0] cnt_q = 16'h0000;
      // enable crosses into the oscillator domain; no reset so the count
      // keeps its value over a system reset
      always_ff @(posedge osc_clk[g]) begin
        en_s1_q <= osc_gate[g];
        en_s2_q <= en_s1_q;
      end
      // free-running count clocked by its own oscillator
      always_ff @(posedge osc_clk[g]) begin
        if (en_s2_q) begin
          cnt_q <= cnt_q + 16'h0001; // [RULE1] [RULE7] [RULE4]
        end
      end
      // a read while running may tear across bits; software waits the stop out
      assign osc_cnt[g] = cnt_q;
    end
  endgenerate

  // ----------------------------------------
  // stop settle tracking
  // ----------------------------------------
  // counts are not resynchronised: the stop/settle window makes them stable
  localparam int unsigned SETTLE = `TSDR_STOP_SETTLE_CYC;
  tsdr_pkg::tsdr_osc_st_t osc_st_q;
  logic [3:0] settle_cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_st_q <= tsdr_pkg::TSDR_OSC_STOPPED;
      settle_cnt_q <= 4'h0;
    end else if (clk_en) begin
      unique case (osc_st_q)
        tsdr_pkg::TSDR_OSC_STOPPED: begin
          if (|osc_ctrl_q) begin
            osc_st_q <= tsdr_pkg::TSDR_OSC_RUNNING;
          end
        end
        tsdr_pkg::TSDR_OSC_RUNNING: begin
          if (~|osc_ctrl_q) begin
            osc_st_q <= tsdr_pkg::TSDR_OSC_SETTLING;
            settle_cnt_q <= 4'h0;
          end
        end
        tsdr_pkg::TSDR_OSC_SETTLING: begin
          if (|osc_ctrl_q) begin
            osc_st_q <= tsdr_pkg::TSDR_OSC_RUNNING;
          end else if (settle_cnt_q == 4'(SETTLE - 1)) begin
            osc_st_q <= tsdr_pkg::TSDR_OSC_STOPPED; // [RULE3]
          end else begin
            settle_cnt_q <= settle_cnt_q + 4'h1;
          end
        end
        default: osc_st_q <= tsdr_pkg::TSDR_OSC_STOPPED;
      endcase
    end
  end

  assign counts_settled = (osc_st_q == tsdr_pkg::TSDR_OSC_STOPPED);

  // ----------------------------------------
  // debug capture registers
  // ----------------------------------------
  logic [`TSDR_SSW_W-1:0] ssw_q;
  logic [31:0] spc_q;
  logic [31:0] ssp_q;
  logic dbg_wr;
  assign dbg_wr = req.wr && debug_mode; // writes outside debug are dropped

  // saved status word: capture on entry, else debug-mode writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ssw_q <= '0;
    end else if (clk_en) begin
      if (debug_entry) begin
        ssw_q <= capt.ssw & `TSDR_SSW_WMASK; // [RULE9] [RULE10] [RULE11] [RULE12]
      end else if (dbg_wr && req.idx == `TSDR_OFS_DBG_SSW) begin
        ssw_q <= req.wdata[`TSDR_SSW_W-1:0] & `TSDR_SSW_WMASK; // [RULE17]
      end
    end
  end

  // saved program counter and stack pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spc_q <= 32'h0000_0000;
      ssp_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (debug_entry) begin
        spc_q <= capt.saved_program_counter; // [RULE13]
        ssp_q <= capt.saved_stack_pointer; // [RULE14]
      end else if (dbg_wr) begin
        if (req.idx == `TSDR_OFS_DBG_SPC) begin
          spc_q <= req.wdata; // [RULE17]
        end
        if (req.idx == `TSDR_OFS_DBG_SSP) begin
          ssp_q <= req.wdata; // [RULE17]
        end
      end
    end
  end

  // ----------------------------------------
  // register fetch operands
  // ----------------------------------------
  logic [`TSDR_THR_W-1:0] thr_q;
  logic [`TSDR_REG_W-1:0] rsel_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_q <= '0;
      rsel_q <= '0;
    end else if (clk_en && dbg_wr) begin
      if (req.idx == `TSDR_OFS_FETCH_THR) begin
        thr_q <= req.wdata[`TSDR_THR_W-1:0]; // [RULE15] [RULE17]
      end
      if (req.idx == `TSDR_OFS_FETCH_REG) begin
        rsel_q <= req.wdata[`TSDR_REG_W-1:0]; // [RULE16] [RULE17]
      end
    end
  end

  assign debug_register_fetch_thread = thr_q;
  assign debug_register_fetch_reg = rsel_q;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [31:0] rd_d;
  logic [31:0] ssw_view;

  // bit 8 shows the live issue mode, bit 5 reads zero
  always_comb begin
    ssw_view = {21'h0, ssw_q};
    ssw_view[`TSDR_SSW_BIT_ISSUE] = cur_issue_mode; // [RULE12]
  end

  // decode; unmapped indices read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (req.idx)
      `TSDR_OFS_OSC_CTRL: rd_d = {30'h0, osc_ctrl_q};
      `TSDR_OFS_OSC_CNT0: rd_d = {16'h0, osc_cnt[0]}; // [RULE5] [RULE6]
      `TSDR_OFS_OSC_CNT1: rd_d = {16'h0, osc_cnt[1]}; // [RULE5] [RULE6]
      `TSDR_OFS_OSC_CNT2: rd_d = {16'h0, osc_cnt[2]}; // [RULE5] [RULE6]
      `TSDR_OFS_OSC_CNT3: rd_d = {16'h0, osc_cnt[3]}; // [RULE5] [RULE6]
      `TSDR_OFS_RAM_SIZE: rd_d = {RAM_BYTES[31:2], 2'h0}; // [RULE8]
      `TSDR_OFS_DBG_SSW: rd_d = ssw_view;
      `TSDR_OFS_DBG_SPC: rd_d = spc_q;
      `TSDR_OFS_DBG_SSP: rd_d = ssp_q;
      `TSDR_OFS_FETCH_THR: rd_d = {24'h0, thr_q};
      `TSDR_OFS_FETCH_REG: rd_d = {27'h0, rsel_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // read data registered: answer one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
      rvalid <= 1'b0;
    end else if (clk_en) begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= rd_d;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ctrl_write_lands: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    clk_en && ctrl_wr |=> osc_ctrl_q == $past(req.wdata[1:0]))
    else $error("oscillator control write not applied");

  a_capture_pc: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
    clk_en && debug_entry |=> spc_q == $past(capt.saved_program_counter))
    else $error("program counter not captured on entry");

  a_capture_sp: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
    clk_en && debug_entry |=> ssp_q == $past(capt.saved_stack_pointer))
    else $error("stack pointer not captured on entry");

  a_capture_status: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
    clk_en && debug_entry |=> ssw_q == ($past(capt.ssw) & `TSDR_SSW_WMASK))
    else $error("status word not captured on entry");

  a_status_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
    ssw_view[`TSDR_SSW_BIT_RSVD] == 1'b0 && ssw_view[31:11] == 21'h0)
    else $error("status reserved bits not zero");

  a_ro_outside_debug: assert property (@(posedge clk) disable iff (!rst_n) // [RULE17]
    clk_en && !debug_mode && !debug_entry |=> $stable(spc_q) && $stable(thr_q))
    else $error("debug field changed outside debug mode");

  a_count_upper_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
    rvalid && $past(req.idx) == `TSDR_OFS_OSC_CNT0 && $past(clk_en) |-> rdata[31:16] == 16'h0)
    else $error("count upper bits not zero");

  a_ram_size_low: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    clk_en && req.rd && req.idx == `TSDR_OFS_RAM_SIZE |=> rdata[1:0] == 2'h0)
    else $error("ram size reserved bits set");

  a_thread_sel: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
    clk_en && dbg_wr && req.idx == `TSDR_OFS_FETCH_THR && !debug_entry
    |=> debug_register_fetch_thread == $past(req.wdata[7:0]))
    else $error("thread operand not written");

  a_settle_after_stop: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    clk_en && osc_st_q == tsdr_pkg::TSDR_OSC_RUNNING && ~|osc_ctrl_q
    |=> !counts_settled [*8] ##1 !counts_settled [*2])
    else $error("settled flagged too early");

  // settle window: the settled flag must not come late either
  a_settle_ends_stop: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    clk_en && osc_st_q == tsdr_pkg::TSDR_OSC_SETTLING && ~|osc_ctrl_q
    && settle_cnt_q == 4'(SETTLE - 1)
    |=> counts_settled)
    else $error("settled not flagged after the stop");

  // clock enable low: nothing in the core domain may move
  a_frozen_no_enable: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    !clk_en
    |=> $stable(osc_ctrl_q) && $stable(osc_st_q) && $stable(spc_q) && $stable(rvalid))
    else $error("state moved while clock enable low");

  // debug-only fields: written in debug, otherwise read-only
  a_status_write_lands: assert property (@(posedge clk) disable iff (!rst_n) // [RULE17]
    clk_en && dbg_wr && !debug_entry && req.idx == `TSDR_OFS_DBG_SSW
    |=> ssw_q == ($past(req.wdata[`TSDR_SSW_W-1:0]) & `TSDR_SSW_WMASK))
    else $error("status word write not applied");

  a_regsel_write_lands: assert property (@(posedge clk) disable iff (!rst_n) // [RULE16]
    clk_en && dbg_wr && req.idx == `TSDR_OFS_FETCH_REG
    |=> debug_register_fetch_reg == $past(req.wdata[`TSDR_REG_W-1:0]))
    else $error("register operand not written");

  a_fields_ro_outside: assert property (@(posedge clk) disable iff (!rst_n) // [RULE17]
    clk_en && !debug_mode && !debug_entry
    |=> $stable(ssw_q) && $stable(ssp_q) && $stable(rsel_q))
    else $error("debug field changed outside debug mode");

  // read answers: one pulse per taken read, values as the rules give them
  a_read_pulse_once: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    clk_en
    |=> rvalid == $past(req.rd))
    else $error("read answer pulse wrong");

  a_count_read_value: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5] [RULE6]
    clk_en && req.rd && req.idx == `TSDR_OFS_OSC_CNT2 && counts_settled && ~|osc_ctrl_q
    |=> rdata == {16'h0, $past(osc_cnt[2])})
    else $error("stopped count read back wrong");

  a_ram_size_value: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    clk_en && req.rd && req.idx == `TSDR_OFS_RAM_SIZE
    |=> rdata[31:2] == RAM_BYTES[31:2])
    else $error("ram size read back wrong");

  a_issue_bit_live: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
    clk_en && req.rd && req.idx == `TSDR_OFS_DBG_SSW
    |=> rdata[`TSDR_SSW_BIT_ISSUE] == $past(cur_issue_mode))
    else $error("live issue mode not shown");

endmodule

//--- verification/tsdr_osc_model.sv
// ring oscillator source standing beside the status bank
// assumes: the bank gates and counts these clocks itself
`timescale 1ns/100ps

module tsdr_osc_model (
  output logic [3:0] osc_clk
);
  // ----------------------------------------
  // oscillators
  // ----------------------------------------
  // free-running at unrelated periods, so no count tracks the core clock
  initial begin
    osc_clk = 4'h0;
    fork
      forever #1.3 osc_clk[0] = ~osc_clk[0];
      forever #1.7 osc_clk[1] = ~osc_clk[1];
      forever #2.3 osc_clk[2] = ~osc_clk[2];
      forever #2.9 osc_clk[3] = ~osc_clk[3];
    join
  end
endmodule

//--- verification/tb_tile_status_debug_regs.sv
// self-checking bench of the tile status/debug bank
// assumes: inputs change at the falling edge; one status access at a time
`timescale 1ns/100ps

module tb_tile_status_debug_regs;
  typedef struct packed {
    logic [7:0] idx;
    logic dbg;
    logic [31:0] wdata;
    logic [31:0] exp;
  } tsdr_row_t;

  logic clk, rst_n, clk_en, rvalid, debug_mode, debug_entry, cur_issue_mode;
  logic core_osc_en, periph_osc_en, counts_settled;
  logic [31:0] rdata, v;
  logic [3:0] osc_clk;
  logic [7:0] fetch_thr;
  logic [4:0] fetch_reg;
  logic [15:0] c [4];
  tsdr_pkg::tsdr_req_t req;
  tsdr_pkg::tsdr_capt_t capt;
  int n_errors = 0;
  int cmp_count = 0;

  // ----------------------------------------
  // write, then read back
  // ----------------------------------------
  // refused rows expect the value left by the last accepted write to the same index
  tsdr_row_t rows [11] = '{
    '{8'h06, 1'b0, 32'hFFFF_FFFF, 32'h0000_0003},
    '{8'h06, 1'b0, 32'h0000_0000, 32'h0000_0000},
    '{8'h13, 1'b1, 32'hFFFF_FFFF, 32'h0000_00FF},
    '{8'h14, 1'b1, 32'hFFFF_FFFF, 32'h0000_001F},
    '{8'h13, 1'b0, 32'h0000_0012, 32'h0000_00FF},
    '{8'h11, 1'b1, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
    '{8'h12, 1'b1, 32'h1234_5678, 32'h1234_5678},
    '{8'h12, 1'b0, 32'h0000_0000, 32'h1234_5678},
    '{8'h10, 1'b1, 32'hFFFF_FFFF, 32'h0000_06DF},
    '{8'h0C, 1'b1, 32'hFFFF_FFFF, 32'h0000_4000},
    '{8'h0B, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000}
  };

  tsdr_tile_status_debug_regs #(.RAM_BYTES(32'h0000_4000)) i_tsdr_tile_status_debug_regs (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .debug_mode(debug_mode),
    .debug_entry(debug_entry),
    .capt(capt),
    .cur_issue_mode(cur_issue_mode),
    .osc_clk(osc_clk),
    .core_osc_en(core_osc_en),
    .periph_osc_en(periph_osc_en),
    .debug_register_fetch_thread(fetch_thr),
    .debug_register_fetch_reg(fetch_reg),
    .counts_settled(counts_settled)
  );

  tsdr_osc_model i_tsdr_osc_model (
    .osc_clk(osc_clk)
  );

  // clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered at a falling edge; single-cycle write strobe
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    req.wr = 1'b1;
    req.idx = idx;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // answer stands for the cycle after the edge that takes the request
  task automatic rd(input logic [7:0] idx, output logic [31:0] val);
    req.rd = 1'b1;
    req.idx = idx;
    @(negedge clk);
    req.rd = 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    val = rdata;
    @(negedge clk);
  endtask

  // counts are only trusted once the stop has settled
  task automatic wait_settled();
    int i;
    for (i = 0; i < 64 && counts_settled !== 1'b1; i++) @(negedge clk);
    if (i == 64) begin
      n_errors++;
      summarize();
    end
  endtask

  // run one set of oscillators, stop, and see which counts moved
  task automatic osc_run(input logic [31:0] en, input logic [3:0] moves);
    wr(8'h06, en);
    chk("osc_en", {30'h0, en[1:0]}, {30'h0, core_osc_en, periph_osc_en});
    repeat (40) @(negedge clk);
    chk("settled_run", 32'h0, {31'h0, counts_settled});
    wr(8'h06, 32'h0);
    wait_settled();
    for (int k = 0; k < 4; k++) begin
      rd(8'h07 + 8'(k), v);
      chk("cnt_hi", 32'h0, {16'h0, v[31:16]});
      chk("cnt_moved", {31'h0, moves[k]}, {31'h0, v[15:0] !== c[k]});
      c[k] = v[15:0];
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    req = '0;
    debug_mode = 1'b0;
    debug_entry = 1'b0;
    capt = '0;
    cur_issue_mode = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk("osc_en_rst", 32'h0, {30'h0, core_osc_en, periph_osc_en});
    rd(8'h06, v);
    chk("ctrl_rst", 32'h0, v);
    foreach (rows[i]) begin
      debug_mode = rows[i].dbg;
      wr(rows[i].idx, rows[i].wdata);
      rd(rows[i].idx, v);
      chk("row", rows[i].exp, v);
    end
    chk("fetch_ops", 32'h1FFF, {19'h0, fetch_thr, fetch_reg});
    // capture must happen outside debug mode too; bit 8 is the live mode
    debug_mode = 1'b0;
    cur_issue_mode = 1'b1;
    capt = {11'h6FF, 32'hCAFE_0011, 32'hBEEF_0022};
    debug_entry = 1'b1;
    @(negedge clk);
    debug_entry = 1'b0;
    rd(8'h10, v);
    chk("ssw", 32'h0000_07DF, v);
    rd(8'h11, v);
    chk("spc", 32'hCAFE_0011, v);
    rd(8'h12, v);
    chk("ssp", 32'hBEEF_0022, v);
    // seed the reference counts; the oscillators have stood still since row 2
    wait_settled();
    for (int k = 0; k < 4; k++) begin
      rd(8'h07 + 8'(k), v);
      c[k] = v[15:0];
    end
    osc_run(32'h3, 4'hF);
    osc_run(32'h2, 4'h3);
    osc_run(32'h1, 4'hC);
    // clock enable low: a write must not land
    clk_en = 1'b0;
    wr(8'h06, 32'h3);
    clk_en = 1'b1;
    rd(8'h06, v);
    chk("ctrl_frozen", 32'h0, v);
    // second reset with all oscillators stopped: counts must come through untouched
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    for (int k = 0; k < 4; k++) begin
      rd(8'h07 + 8'(k), v);
      chk("cnt_kept", {16'h0, c[k]}, v);
    end
    summarize();
  end
endmodule
